// >>> rtl/qsr_pkg.sv
// qsr_pkg: constants for the quad bidirectional recirculating shift register
// assumes: included before every qsr design module
package qsr_pkg;
	localparam int QSR_LEN_LONG = 133;
	localparam int QSR_LEN_SHORT = 81;
	localparam int QSR_NUM_REGS = 4;
	localparam int QSR_FIFO_DEPTH = 16;
	localparam int QSR_SYNC_STAGES = 3;
	localparam logic QSR_DIR_RIGHT = 1'h0;
	localparam logic QSR_DIR_LEFT = 1'h1;
	localparam logic [3:0] QSR_RST_VAL = 4'h0;
	typedef enum logic [1:0] {QSR_ST_IDLE, QSR_ST_STEP} qsr_state_t;
endpackage

// >>> rtl/qsr_fifo.sv
// qsr_fifo: synchronous fifo with valid/ready on both sides
// assumes: single clock, synchronous active-high reset
`timescale 1ns/1ps
module qsr_fifo
	import qsr_pkg::*;
#(
	parameter int WIDTH = 4,
	parameter int DEPTH = QSR_FIFO_DEPTH
) (
	input wire logic ref_clk_in, // system clock
	input wire logic rst_in, // synchronous reset
	input wire logic in_valid_in, // write request
	output logic in_ready_out, // space available
	input wire logic [WIDTH-1:0] in_data_in, // write word
	output logic out_valid_out, // word available
	input wire logic out_ready_in, // read accept
	output logic [WIDTH-1:0] out_data_out // head word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic push, pop;

	assign in_ready_out = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid_out = (cnt_r != '0);
	assign out_data_out = mem_r[rd_r];
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;

	always_comb begin
		wr_nxt = push ? wr_r + 1'b1 : wr_r;
		rd_nxt = pop ? rd_r + 1'b1 : rd_r;
		cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (push) begin
			mem_r[wr_r] <= in_data_in;
		end
	end
endmodule

// >>> rtl/qsr_quad_shift.sv
// qsr_quad_shift: four static shift registers with shared direction control
// assumes: pins arrive asynchronously; shift steps are rising edges of step pin
`timescale 1ns/1ps
// Summary of operation
// - four independent shift registers, 133 or 81 bits long.
// - each register has its own serial input and serial output.
// - one direction select governs all four registers together.
// - direction low loads and shifts right; high shifts left.
// - recirculate select abc feeds outputs of a, b, c back to inputs.
// - recirculate select d takes d input from recirculate input d pin.
// - clear forces outputs low without waiting for a step and clears all registers.
// - new bit enters on each rising step edge when recirculate low.
// - serial outputs change only on a rising step edge or when clear goes high.
// - contents hold unchanged while step clock is stopped.
// - last bit position is usable as flag storage.
module qsr_quad_shift
	import qsr_pkg::*;
#(
	parameter int LEN = QSR_LEN_LONG,
	parameter int FIFO_DEPTH = QSR_FIFO_DEPTH
) (
	input wire logic ref_clk_in, // 200 MHz system clock
	input wire logic rst_in, // synchronous reset
	input wire logic step_clk_in, // shift clock pin
	input wire logic clear_input_in, // clear pin, high active
	input wire logic shift_direction_select_in, // low right/load, high left
	input wire logic recirc_select_abc_in, // recirculate a, b, c
	input wire logic recirc_select_d_in, // recirculate d from pin
	input wire logic recirc_input_d_in, // alternate d input
	input wire logic [3:0] serial_in_in, // data inputs d..a
	output logic serial_out_a_out, // register a output
	output logic serial_out_b_out, // register b output
	output logic serial_out_c_out, // register c output
	output logic serial_out_d_out, // register d output
	output logic [3:0] flag_bits_out, // last positions d..a
	output logic step_overrun_out // step lost, fifo full
);
	localparam int NP = 6;
	logic [NP-1:0] pin_async;
	logic [NP-1:0] s1_r, s2_r, s3_r, s1_nxt, s2_nxt, s3_nxt;
	logic [NP-1:0] pins;
	logic step_lvl, clr_lvl;
	logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
	logic [5:0] fifo_out_data;
	logic [LEN-1:0] sr_r [QSR_NUM_REGS];
	logic [LEN-1:0] sr_nxt [QSR_NUM_REGS];
	logic [3:0] out_r, out_nxt;
	logic step_prev_r, step_prev_nxt;
	logic ovr_r, ovr_nxt;
	logic step_rise;
	logic [3:0] in_bit;
	qsr_state_t st_r, st_nxt;

	assign pin_async = {step_clk_in, clear_input_in, shift_direction_select_in,
		recirc_select_abc_in, recirc_select_d_in, recirc_input_d_in};

	// three-stage pin synchroniser; change accepted when stages two and three agree
	always_comb begin
		s1_nxt = pin_async;
		s2_nxt = s1_r;
		s3_nxt = s2_r;
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
		end
	end

	logic [NP-1:0] pins_r, pins_nxt;
	always_comb begin
		for (int i = 0; i < NP; i++) begin
			pins_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : pins_r[i];
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			pins_r <= '0;
		end else begin
			pins_r <= pins_nxt;
		end
	end

	assign pins = pins_r;
	assign step_lvl = pins[5];
	assign clr_lvl = pins[4];

	// serial data sampled in a separate stage bank with the same timing as the controls
	logic [3:0] d1_r, d2_r, d3_r, dq_r, d1_nxt, d2_nxt, d3_nxt, dq_nxt;
	always_comb begin
		d1_nxt = serial_in_in;
		d2_nxt = d1_r;
		d3_nxt = d2_r;
		for (int i = 0; i < 4; i++) begin
			dq_nxt[i] = (d2_r[i] == d3_r[i]) ? d3_r[i] : dq_r[i];
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			d1_r <= QSR_RST_VAL;
			d2_r <= QSR_RST_VAL;
			d3_r <= QSR_RST_VAL;
			dq_r <= QSR_RST_VAL;
		end else begin
			d1_r <= d1_nxt;
			d2_r <= d2_nxt;
			d3_r <= d3_nxt;
			dq_r <= dq_nxt;
		end
	end

	// rising step edge with its controls queued in order
	assign step_rise = step_lvl && !step_prev_r;

	qsr_fifo #(
		.WIDTH(6),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in || clr_lvl),
		.in_valid_in(step_rise && !clr_lvl),
		.in_ready_out(fifo_in_ready),
		.in_data_in({pins[3], pins[2], pins[1], pins[0], dq_r[3], dq_r[0]}),
		.out_valid_out(fifo_out_valid),
		.out_ready_in(fifo_out_ready),
		.out_data_out(fifo_out_data)
	);

	// b and c data carried from sampled bank at step time
	logic [1:0] bc_q [FIFO_DEPTH];
	logic [$clog2(FIFO_DEPTH)-1:0] bcw_r, bcw_nxt, bcr_r, bcr_nxt;

	always_comb begin
		bcw_nxt = (step_rise && !clr_lvl && fifo_in_ready) ? bcw_r + 1'b1 : bcw_r;
		bcr_nxt = (fifo_out_valid && fifo_out_ready) ? bcr_r + 1'b1 : bcr_r;
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in || clr_lvl) begin
			bcw_r <= '0;
			bcr_r <= '0;
		end else begin
			bcw_r <= bcw_nxt;
			bcr_r <= bcr_nxt;
		end
		if (step_rise && !clr_lvl && fifo_in_ready) begin
			bc_q[bcw_r] <= dq_r[2:1];
		end
	end

	// one queued step applied per idle->step cycle
	always_comb begin
		st_nxt = st_r;
		fifo_out_ready = 1'b0;
		unique case (st_r)
			QSR_ST_IDLE: begin
				if (fifo_out_valid) begin
					st_nxt = QSR_ST_STEP;
				end
			end
			QSR_ST_STEP: begin
				fifo_out_ready = 1'b1;
				st_nxt = QSR_ST_IDLE;
			end
		endcase
	end

	always_comb begin
		in_bit = {fifo_out_data[1], bc_q[bcr_r], fifo_out_data[0]};
		if (fifo_out_data[4]) begin
			in_bit[0] = out_r[0];
			in_bit[1] = out_r[1];
			in_bit[2] = out_r[2];
		end
		if (fifo_out_data[3]) begin
			in_bit[3] = fifo_out_data[2];
		end
		for (int r = 0; r < QSR_NUM_REGS; r++) begin
			sr_nxt[r] = sr_r[r];
			if (fifo_out_ready) begin
				if (fifo_out_data[5] == QSR_DIR_LEFT) begin
					sr_nxt[r] = {sr_r[r][LEN-2:0], in_bit[r]};
				end else begin
					sr_nxt[r] = {in_bit[r], sr_r[r][LEN-1:1]};
				end
			end
			out_nxt[r] = (fifo_out_data[5] == QSR_DIR_LEFT) ? sr_nxt[r][LEN-1] : sr_nxt[r][0];
			if (!fifo_out_ready) begin
				out_nxt[r] = out_r[r];
			end
		end
		step_prev_nxt = step_lvl;
		ovr_nxt = ovr_r | (step_rise && !clr_lvl && !fifo_in_ready);
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in || clr_lvl) begin
			for (int r = 0; r < QSR_NUM_REGS; r++) begin
				sr_r[r] <= '0;
			end
			out_r <= QSR_RST_VAL;
			st_r <= QSR_ST_IDLE;
			ovr_r <= 1'b0;
		end else begin
			for (int r = 0; r < QSR_NUM_REGS; r++) begin
				sr_r[r] <= sr_nxt[r];
			end
			out_r <= out_nxt;
			st_r <= st_nxt;
			ovr_r <= ovr_nxt;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			step_prev_r <= 1'b0;
		end else begin
			step_prev_r <= step_prev_nxt;
		end
	end

	// clear drives outputs low without waiting for a step
	assign serial_out_a_out = out_r[0] & ~clr_lvl;
	assign serial_out_b_out = out_r[1] & ~clr_lvl;
	assign serial_out_c_out = out_r[2] & ~clr_lvl;
	assign serial_out_d_out = out_r[3] & ~clr_lvl;
	always_comb begin
		for (int r = 0; r < QSR_NUM_REGS; r++) begin
			flag_bits_out[r] = sr_r[r][LEN-1];
		end
	end
	assign step_overrun_out = ovr_r;
endmodule

// >>> test/qsr_quad_shift_chk.sv
// checker on the qsr_quad_shift ports
// assumes: bound to every qsr_quad_shift instance
`timescale 1ns/1ps
module qsr_quad_shift_chk (
	input wire logic ref_clk_in, // clk
	input wire logic rst_in, // reset
	input wire logic step_clk_in, // step pin
	input wire logic clear_input_in, // clear
	input wire logic serial_out_a_out, // out a
	input wire logic serial_out_b_out, // out b
	input wire logic serial_out_c_out, // out c
	input wire logic serial_out_d_out, // out d
	input wire logic [3:0] flag_bits_out // flags
);
	logic [7:0] v;
	logic p_r;
	logic [3:0] ri_r, ri_nxt, cl_r, cl_nxt;
	assign v = {flag_bits_out, serial_out_d_out, serial_out_c_out, serial_out_b_out, serial_out_a_out};
	// cycles since a step rise and since clear was high
	always_comb begin
		ri_nxt = (step_clk_in && !p_r) ? 4'h0 : ri_r + {3'h0, ri_r != 4'hF};
		cl_nxt = clear_input_in ? 4'h0 : cl_r + {3'h0, cl_r != 4'hF};
	end
	always_ff @(posedge ref_clk_in) begin
		p_r <= step_clk_in;
		ri_r <= rst_in ? 4'hF : ri_nxt;
		cl_r <= rst_in ? 4'hF : cl_nxt;
	end
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	property p_clr_out; clear_input_in [*6] |-> v[3:0] == 4'h0; endproperty
	a_clr_out: assert property (p_clr_out) else $error("outputs not cleared");
	property p_clr_flag; clear_input_in [*6] |-> v[7:4] == 4'h0; endproperty
	a_clr_flag: assert property (p_clr_flag) else $error("flags not cleared");
	property p_clr_rise; $rose(clear_input_in) |-> ##[3:6] v == 8'h00; endproperty
	a_clr_rise: assert property (p_clr_rise) else $error("clear too slow");
	property p_clr_step; clear_input_in [*6] ##1 (clear_input_in && $rose(step_clk_in)) |-> (v == 8'h00) [*8];
	endproperty
	a_clr_step: assert property (p_clr_step) else $error("step acted during clear");
	property p_hold_lo; (!step_clk_in && !clear_input_in) [*8] |=> $stable(v); endproperty
	a_hold_lo: assert property (p_hold_lo) else $error("changed with step low");
	property p_hold_hi; (step_clk_in && !clear_input_in) [*8] |=> $stable(v); endproperty
	a_hold_hi: assert property (p_hold_hi) else $error("changed with step high");
	property p_chg_late; $changed(v) |-> ri_r >= 4'h2 || cl_r <= 4'h6; endproperty
	a_chg_late: assert property (p_chg_late) else $error("change before step");
	property p_chg_soon; $changed(v) |-> ri_r <= 4'hA || cl_r <= 4'h6; endproperty
	a_chg_soon: assert property (p_chg_soon) else $error("change without step");
endmodule
bind qsr_quad_shift qsr_quad_shift_chk u_chk (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .step_clk_in(step_clk_in),
	.clear_input_in(clear_input_in), .serial_out_a_out(serial_out_a_out), .serial_out_b_out(serial_out_b_out),
	.serial_out_c_out(serial_out_c_out), .serial_out_d_out(serial_out_d_out), .flag_bits_out(flag_bits_out));

// >>> test/qsr_step_src.sv
// outside logic pulsing the step pin once per shift
// assumes: go_in is ignored while a pulse runs
`timescale 1ns/1ps
module qsr_step_src (
	input wire logic ref_clk_in, // clk
	input wire logic rst_in, // reset
	input wire logic go_in, // start one step
	output logic step_clk_out, // step pin
	output logic done_out // pulse over
);
	logic [4:0] cnt_r, cnt_nxt;
	always_comb begin
		cnt_nxt = cnt_r;
		if (cnt_r != 5'h00)
			cnt_nxt = (cnt_r == 5'h10) ? 5'h00 : cnt_r + 5'h01;
		else if (go_in)
			cnt_nxt = 5'h01;
	end
	always_ff @(posedge ref_clk_in) begin
		cnt_r <= rst_in ? 5'h00 : cnt_nxt;
	end
	// idle low, eight cycles high, eight low
	assign step_clk_out = cnt_r != 5'h00 && cnt_r < 5'h09;
	assign done_out = cnt_r == 5'h10;
endmodule

// >>> test/testbench.sv
// testbench: random shifts of all four registers against a bit model
// assumes: qsr_step_src makes the step pin
`timescale 1ns/1ps
module testbench;
	import qsr_pkg::*;
	localparam int L = QSR_LEN_SHORT;
	logic clk = 0, rst = 1, clr = 0, dir = 0, rabc = 0, rd = 0, recirc_input_d = 0, go = 0, stp, dn;
	logic [3:0] din = 4'h0, fl, mo = 4'h0;
	logic ovr;
	wire [3:0] oo;
	logic [L-1:0] m [4];
	logic [7:0] q [$];
	logic [15:0] lf = 16'h0063;
	int failures = 0, samples_checked = 0;
	qsr_step_src u_src (.ref_clk_in(clk), .rst_in(rst), .go_in(go), .step_clk_out(stp), .done_out(dn));
	qsr_quad_shift #(.LEN(L)) DUT (.ref_clk_in(clk), .rst_in(rst), .step_clk_in(stp), .clear_input_in(clr),
		.shift_direction_select_in(dir), .recirc_select_abc_in(rabc), .recirc_select_d_in(rd),
		.recirc_input_d_in(recirc_input_d), .serial_in_in(din), .serial_out_a_out(oo[0]), .serial_out_b_out(oo[1]),
		.serial_out_c_out(oo[2]), .serial_out_d_out(oo[3]), .flag_bits_out(fl), .step_overrun_out(ovr));
	initial forever #2.5 clk = ~clk;
	function automatic logic [15:0] nx(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic report_and_stop;
		if (failures == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// one step: update the model, note the expected outputs, pulse and wait
	task automatic step(input logic d, input logic ra, input logic r);
		logic [7:0] e;
		logic b;
		int i;
		lf = nx(lf);
		@(posedge clk);
		dir <= d;
		rabc <= ra;
		rd <= r;
		din <= lf[3:0];
		recirc_input_d <= lf[4];
		go <= 1'b1;
		for (i = 0; i < 4; i++) begin
			// recirculation feeds back what the output pin shows now
			b = (i < 3 && ra) ? mo[i] : (i == 3 && r) ? lf[4] : lf[i];
			m[i] = d ? {m[i][L-2:0], b} : {b, m[i][L-1:1]};
			if (clr)
				m[i] = '0;
			e[i] = d ? m[i][L-1] : m[i][0];
			e[i+4] = m[i][L-1];
		end
		mo = e[3:0];
		q.push_back(e);
		@(posedge clk);
		go <= 1'b0;
		for (i = 0; i < 40 && !dn; i++)
			@(posedge clk);
		if (!dn) begin
			failures++;
			report_and_stop();
		end
	endtask
	always @(posedge clk) begin
		if (dn) begin
			if (q.size() == 0)
				chk("queue", 8'h01, 8'h00);
			else
				chk("outputs", q.pop_front(), {fl, oo});
		end
	end
	initial begin
		for (int i = 0; i < 4; i++)
			m[i] = '0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("reset", 8'h00, {fl, oo});
		for (int k = 0; k < L + 4; k++)
			step(QSR_DIR_RIGHT, 1'b0, 1'b0);
		repeat (200) @(posedge clk);
		for (int k = 0; k < L + 4; k++)
			step(QSR_DIR_LEFT, 1'b0, 1'b0);
		for (int k = 0; k < 60; k++)
			step(lf[5], lf[7], lf[6]);
		clr <= 1'b1;
		repeat (6) @(posedge clk);
		step(QSR_DIR_RIGHT, 1'b0, 1'b0);
		clr <= 1'b0;
		repeat (8) @(posedge clk);
		for (int k = 0; k < 6; k++)
			step(lf[5], 1'b0, 1'b0);
		chk("overrun", 8'h00, {7'h00, ovr});
		report_and_stop();
	end
endmodule
